// ===== rtl/rbt_pkg.sv
/*
 * rbt_pkg: sub-addresses, field positions, reset values and output levels
 * for the RGB blanking and cut-off reference timing block.
 * Assumes 8-bit register bytes and 8-bit digital video codes (0 = 0 IRE).
 */
package rbt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register sub-addresses
   localparam logic [7:0] RBT_ADDR_VIDEO_EN = 8'h00;
   localparam logic [7:0] RBT_ADDR_AGING    = 8'h0F;
   localparam logic [7:0] RBT_ADDR_CUTOFF   = 8'h14;
   localparam logic [7:0] RBT_ADDR_VBLANK   = 8'h15;
   localparam logic [7:0] RBT_ADDR_VSELECT  = 8'h1D;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int RBT_BIT_MASTER_EN   = 7;
   localparam int RBT_BIT_RED_EN      = 6;
   localparam int RBT_BIT_GREEN_EN    = 5;
   localparam int RBT_BIT_BLUE_EN     = 4;
   localparam int RBT_BIT_AGING_W     = 1;
   localparam int RBT_BIT_AGING_B     = 0;
   localparam int RBT_POS_REF_LINE    = 3;
   localparam int RBT_BIT_BLANK_DIS   = 1;
   localparam int RBT_BIT_CUTOFF_MODE = 0;
   localparam int RBT_POS_TOP_BLANK   = 4;
   localparam int RBT_POS_BOT_BLANK   = 0;
   localparam int RBT_BIT_VBLANK_SEL  = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic       RBT_RST_MASTER_EN   = 1'h0;
   localparam logic       RBT_RST_CHAN_EN     = 1'h1;
   localparam logic       RBT_RST_AGING       = 1'h0;
   localparam logic       RBT_RST_CUTOFF_MODE = 1'h0;
   localparam logic       RBT_RST_BLANK_DIS   = 1'h0;
   localparam logic [4:0] RBT_RST_REF_LINE    = 5'h00;
   localparam logic [3:0] RBT_RST_BLANK_LINES = 4'h0;
   localparam logic       RBT_RST_VBLANK_SEL  = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   // line timing and output levels
   localparam logic [5:0] RBT_REF_LINE_BASE = 6'h0A;  // code 0 -> line 10
   localparam int         RBT_LINE_W        = 11;
   localparam logic [7:0] RBT_LVL_BLACK     = 8'h00;  // 0 IRE
   localparam logic [7:0] RBT_LVL_WHITE     = 8'hCC;  // 80 IRE
   localparam logic [7:0] RBT_LVL_BLANK_OFF = 8'h14;  // about 8 IRE
   localparam logic [7:0] RBT_LVL_REF       = 8'h1A;  // cut-off reference pulse

endpackage

// ===== rtl/rbt_timing.sv
/*
 * rbt_timing: gates the RGB video codes, places the cut-off reference
 * pulses and the vertical blanking window of each field.
 * Assumes line, sync, blanking and format pins are asynchronous levels,
 * and the register port and video codes come from the sys_clk_i domain.
 */
`timescale 1ns/1ps

// Summary of operation
// (R01) Master enable zero blanks all outputs and pulses; clears on reset.
// (R02) Channel enables gate only video; reference pulses stay regardless.
// (R03) Cutoff mode zero runs automatic loop with pulses; one is manual.
// (R04) Manual mode: blanking switch zero blanks, one leaves about 8 IRE.
// (R05) Blue pulse line is ten plus the five-bit code after vsync rise.
// (R06) With vertical select, top field blanks that many lines after pulse.
// (R07) Top step is one line for 480i, two lines otherwise.
// (R08) With vertical select, bottom field blanks lines before vsync, same step.
// (R09) White aging forces all outputs to 80 IRE unless black aging is also set or master enable is zero.
// (R10) Black aging forces all outputs to 0 IRE.
// (R11) Line counter restarts on vsync rise, advances per line; windows decode it.
module rbt_timing
   import rbt_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       resetn_i,
   // line timing pins
   input  wire logic       hsync_pin_i,
   input  wire logic       vsync_pin_i,
   input  wire logic       hblank_pin_i,
   input  wire logic       fmt_480i_pin_i,
   // register port
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // video in and out
   input  wire logic [7:0] red_i,
   input  wire logic [7:0] green_i,
   input  wire logic [7:0] blue_i,
   output logic      [7:0] red_o,
   output logic      [7:0] green_o,
   output logic      [7:0] blue_o,
   // timing state
   output logic            ref_pulse_o,
   output logic            vblank_o
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic       rst_s1_reg;
   logic       rst_n;
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic       hs_d_reg;
   logic       vs_d_reg;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_reg <= 1'h0;
         rst_n      <= 1'h0;
      end else begin
         rst_s1_reg <= 1'h1;
         rst_n      <= rst_s1_reg;
      end
   end

   // two flops per pin, then edge history
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= 4'h0;
         pin_s2_reg <= 4'h0;
         hs_d_reg   <= 1'h0;
         vs_d_reg   <= 1'h0;
      end else begin
         pin_s1_reg <= {fmt_480i_pin_i, hblank_pin_i, vsync_pin_i, hsync_pin_i};
         pin_s2_reg <= pin_s1_reg;
         hs_d_reg   <= pin_s2_reg[0];
         vs_d_reg   <= pin_s2_reg[1];
      end
   end

   wire logic hs_rise  = pin_s2_reg[0] & ~hs_d_reg;
   wire logic vs_rise  = pin_s2_reg[1] & ~vs_d_reg;
   wire logic hblank   = pin_s2_reg[2];
   wire logic fmt_480i = pin_s2_reg[3];

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   logic       master_en_reg;
   logic       red_en_reg;
   logic       green_en_reg;
   logic       blue_en_reg;
   logic       aging_w_reg;
   logic       aging_b_reg;
   logic       cutoff_mode_reg;
   logic       blank_dis_reg;
   logic [4:0] ref_line_code_reg;
   logic [3:0] top_blank_reg;
   logic [3:0] bot_blank_reg;
   logic       vblank_sel_reg;

   wire logic wr_video  = reg_wr_i && (reg_addr_i == RBT_ADDR_VIDEO_EN);
   wire logic wr_aging  = reg_wr_i && (reg_addr_i == RBT_ADDR_AGING);
   wire logic wr_cutoff = reg_wr_i && (reg_addr_i == RBT_ADDR_CUTOFF);
   wire logic wr_vblank = reg_wr_i && (reg_addr_i == RBT_ADDR_VBLANK);
   wire logic wr_vsel   = reg_wr_i && (reg_addr_i == RBT_ADDR_VSELECT);

   // register writes by sub-address
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         master_en_reg     <= RBT_RST_MASTER_EN;  // [R01]
         red_en_reg        <= RBT_RST_CHAN_EN;
         green_en_reg      <= RBT_RST_CHAN_EN;
         blue_en_reg       <= RBT_RST_CHAN_EN;
         aging_w_reg       <= RBT_RST_AGING;
         aging_b_reg       <= RBT_RST_AGING;
         cutoff_mode_reg   <= RBT_RST_CUTOFF_MODE;
         blank_dis_reg     <= RBT_RST_BLANK_DIS;
         ref_line_code_reg <= RBT_RST_REF_LINE;
         top_blank_reg     <= RBT_RST_BLANK_LINES;
         bot_blank_reg     <= RBT_RST_BLANK_LINES;
         vblank_sel_reg    <= RBT_RST_VBLANK_SEL;
      end else begin
         if (wr_video) begin
            master_en_reg <= reg_wdata_i[RBT_BIT_MASTER_EN];
            red_en_reg    <= reg_wdata_i[RBT_BIT_RED_EN];
            green_en_reg  <= reg_wdata_i[RBT_BIT_GREEN_EN];
            blue_en_reg   <= reg_wdata_i[RBT_BIT_BLUE_EN];
         end
         if (wr_aging) begin
            aging_w_reg <= reg_wdata_i[RBT_BIT_AGING_W];
            aging_b_reg <= reg_wdata_i[RBT_BIT_AGING_B];
         end
         if (wr_cutoff) begin
            ref_line_code_reg <= reg_wdata_i[RBT_POS_REF_LINE +: 5];
            blank_dis_reg     <= reg_wdata_i[RBT_BIT_BLANK_DIS];
            cutoff_mode_reg   <= reg_wdata_i[RBT_BIT_CUTOFF_MODE];
         end
         if (wr_vblank) begin
            top_blank_reg <= reg_wdata_i[RBT_POS_TOP_BLANK +: 4];
            bot_blank_reg <= reg_wdata_i[RBT_POS_BOT_BLANK +: 4];
         end
         if (wr_vsel) begin
            vblank_sel_reg <= reg_wdata_i[RBT_BIT_VBLANK_SEL];
         end
      end
   end

   // read-back mux; unmapped sub-addresses read zero
   logic [7:0] rd_mux;
   always_comb begin
      if (reg_addr_i == RBT_ADDR_VIDEO_EN) begin
         rd_mux = {master_en_reg, red_en_reg, green_en_reg, blue_en_reg, 4'h0};
      end else if (reg_addr_i == RBT_ADDR_AGING) begin
         rd_mux = {6'h00, aging_w_reg, aging_b_reg};
      end else if (reg_addr_i == RBT_ADDR_CUTOFF) begin
         rd_mux = {ref_line_code_reg, 1'h0, blank_dis_reg, cutoff_mode_reg};
      end else if (reg_addr_i == RBT_ADDR_VBLANK) begin
         rd_mux = {top_blank_reg, bot_blank_reg};
      end else if (reg_addr_i == RBT_ADDR_VSELECT) begin
         rd_mux = {7'h00, vblank_sel_reg};
      end else begin
         rd_mux = 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line counter and field length
   logic [RBT_LINE_W-1:0] line_reg;
   logic [RBT_LINE_W-1:0] field_len_reg;
   wire  logic            line_max = &line_reg;

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         line_reg      <= '0;
         field_len_reg <= '0;
      end else if (vs_rise) begin
         line_reg      <= '0;  // [R11]
         field_len_reg <= line_reg;
      end else if (hs_rise && !line_max) begin
         line_reg <= line_reg + 1'b1;  // [R11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // window decode from the line counter
   wire logic [5:0] ref_line_b = RBT_REF_LINE_BASE + {1'b0, ref_line_code_reg};  // [R05]
   wire logic [5:0] ref_line_g = ref_line_b - 6'h01;
   wire logic [5:0] ref_line_r = ref_line_b - 6'h02;
   // one line per code step for 480i, two otherwise
   wire logic [4:0] top_lines  = fmt_480i ? {1'b0, top_blank_reg} : {top_blank_reg, 1'b0};  // [R07]
   wire logic [4:0] bot_lines  = fmt_480i ? {1'b0, bot_blank_reg} : {bot_blank_reg, 1'b0};  // [R08]
   wire logic [6:0] top_end    = vblank_sel_reg ? {1'b0, ref_line_b} + {2'b00, top_lines}
                                                : {1'b0, ref_line_b};  // [R06]
   wire logic [RBT_LINE_W-1:0] bot_start = field_len_reg - {{(RBT_LINE_W-5){1'b0}}, bot_lines};
   wire logic top_win = line_reg <= {{(RBT_LINE_W-7){1'b0}}, top_end};  // [R06]
   wire logic bot_win = vblank_sel_reg && (bot_lines != 5'h00)
                        && (field_len_reg > {{(RBT_LINE_W-5){1'b0}}, bot_lines})
                        && (line_reg >= bot_start);  // [R08]
   wire logic vwin    = top_win | bot_win;
   wire logic auto_on = ~cutoff_mode_reg;  // [R03]
   wire logic ref_r   = auto_on && (line_reg == {{(RBT_LINE_W-6){1'b0}}, ref_line_r});
   wire logic ref_g   = auto_on && (line_reg == {{(RBT_LINE_W-6){1'b0}}, ref_line_g});
   wire logic ref_b   = auto_on && (line_reg == {{(RBT_LINE_W-6){1'b0}}, ref_line_b});  // [R05]
   wire logic blank   = vwin | hblank;
   // blanking suppressed only in manual cut-off with the switch set
   wire logic [7:0] blank_lvl = (cutoff_mode_reg && blank_dis_reg) ? RBT_LVL_BLANK_OFF
                                                                  : RBT_LVL_BLACK;  // [R04]

   ////////////////////////////////////////////////////////////////////////////
   // output level selection, highest priority first
   function automatic logic [7:0] pick(input logic en, input logic refp, input logic [7:0] vid,
                                       input logic [7:0] blk, input logic bl, input logic mst,
                                       input logic aw, input logic ab);
      logic [7:0] v;
      v = RBT_LVL_BLACK;
      if (!mst) begin
         v = RBT_LVL_BLACK;  // [R01]
      end else if (ab) begin
         v = RBT_LVL_BLACK;  // [R10]
      end else if (aw) begin
         v = RBT_LVL_WHITE;  // [R09]
      end else if (refp) begin
         v = RBT_LVL_REF;  // [R02]
      end else if (bl) begin
         v = blk;
      end else if (en) begin
         v = vid;
      end
      return v;
   endfunction

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         red_o       <= RBT_LVL_BLACK;
         green_o     <= RBT_LVL_BLACK;
         blue_o      <= RBT_LVL_BLACK;
         ref_pulse_o <= 1'h0;
         vblank_o    <= 1'h0;
      end else begin
         red_o       <= pick(red_en_reg, ref_r, red_i, blank_lvl, blank,
                             master_en_reg, aging_w_reg, aging_b_reg);
         green_o     <= pick(green_en_reg, ref_g, green_i, blank_lvl, blank,
                             master_en_reg, aging_w_reg, aging_b_reg);
         blue_o      <= pick(blue_en_reg, ref_b, blue_i, blank_lvl, blank,
                             master_en_reg, aging_w_reg, aging_b_reg);
         ref_pulse_o <= master_en_reg & ref_b;  // [R03]
         vblank_o    <= vwin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   wire logic quiet = master_en_reg && !aging_w_reg && !aging_b_reg;

   AST_MASTER_OFF: assert property (!master_en_reg |=> (red_o == 8'h00) && (green_o == 8'h00)
                                    && (blue_o == 8'h00) && !ref_pulse_o)  // [R01]
      else $error("outputs not blanked with master enable low");
   AST_CHAN_OFF: assert property (quiet && !red_en_reg && !ref_r && !blank |=> red_o == 8'h00)  // [R02]
      else $error("disabled red channel passed video");
   AST_REF_KEEP: assert property (quiet && ref_b |=> blue_o == RBT_LVL_REF)  // [R02]
      else $error("blue reference pulse missing");
   AST_MANUAL_NO_REF: assert property (cutoff_mode_reg |=> !ref_pulse_o)  // [R03]
      else $error("reference pulse in manual cut-off");
   AST_BLANK_OFF: assert property (quiet && cutoff_mode_reg && blank_dis_reg && blank
                                   |=> green_o == RBT_LVL_BLANK_OFF)  // [R04]
      else $error("blanking not suppressed to 8 IRE level");
   AST_REF_LINE: assert property (quiet && auto_on  // [R05]
                                  && (line_reg == 11'(ref_line_code_reg) + 11'(RBT_REF_LINE_BASE))
                                  |=> ref_pulse_o)  // [R05]
      else $error("reference pulse not on code plus ten");
   AST_TOP: assert property (vblank_sel_reg && (line_reg > 11'(ref_line_b))
                             && (line_reg <= 11'(ref_line_b) + 11'(fmt_480i ? top_blank_reg
                                                                   : top_blank_reg * 2))
                             |=> vblank_o)  // [R06]
      else $error("top blanking window missed");
   // bottom window rebuilt from the last field length and the per-code step
   AST_BOT: assert property (vblank_sel_reg && (bot_blank_reg != 4'h0)  // [R08]
                             && (field_len_reg > 11'(fmt_480i ? bot_blank_reg : bot_blank_reg * 2))
                             && (line_reg + 11'(fmt_480i ? bot_blank_reg : bot_blank_reg * 2) >= field_len_reg)
                             |=> vblank_o)  // [R08]
      else $error("bottom blanking window missed");
   AST_WHITE: assert property (master_en_reg && aging_w_reg && !aging_b_reg
                               |=> red_o == RBT_LVL_WHITE && blue_o == RBT_LVL_WHITE)  // [R09]
      else $error("white aging level wrong");
   AST_BLACK: assert property (aging_b_reg |=> red_o == 8'h00 && green_o == 8'h00)  // [R10]
      else $error("black aging level wrong");
   AST_LINE_RESTART: assert property (vs_rise |=> line_reg == '0)  // [R11]
      else $error("line counter did not restart");
   AST_LINE_ADV: assert property (hs_rise && !vs_rise && !line_max
                                  |=> line_reg == $past(line_reg) + 1'b1)  // [R11]
      else $error("line counter did not advance");

   CVR_REF: cover property (ref_pulse_o);
   CVR_BOT: cover property (bot_win ##1 vblank_o);
   CVR_WHITE: cover property (master_en_reg && aging_w_reg ##1 red_o == RBT_LVL_WHITE);

endmodule

// ===== verif/rbt_sync_src.sv
/*
 * rbt_sync_src: model of the line and field sync source ahead of the block.
 * Assumes the caller steps it from one process; pins change after clock edges.
 */
`timescale 1ns/1ps

module rbt_sync_src (
   // clock
   input  wire logic sys_clk_i,
   // sync pins
   output logic      hsync_o,
   output logic      vsync_o
);

   ////////////////////////////////////////////////////////////////////////////
   // idle levels at time zero
   initial begin
      hsync_o = 1'h0;
      vsync_o = 1'h0;
   end

   // vsync pulse mid-line, well apart from any hsync edge
   task automatic field_start();
      @(posedge sys_clk_i);
      vsync_o <= 1'h1;  // restarts the line count
      repeat (4) @(posedge sys_clk_i);
      vsync_o <= 1'h0;
      repeat (8) @(posedge sys_clk_i);
      #1;
   endtask

   // n whole lines, hsync high 4 cycles then low 13 before the next rise
   task automatic line_step(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         hsync_o <= 1'h1;  // one line advance each rise
         repeat (4) @(posedge sys_clk_i);
         hsync_o <= 1'h0;
         repeat (12) @(posedge sys_clk_i);
      end
      #1;
   endtask

endmodule

// ===== verif/rbt_timing_tb.sv
/*
 * rbt_timing_tb: register sequences and field walks with expected outputs.
 * Assumes rbt_sync_src drives the sync pins and rbt_pkg holds the levels.
 */
`timescale 1ns/1ps

module rbt_timing_tb;
   import rbt_pkg::*;

   logic       sys_clk_i;
   logic       resetn_i;
   logic       hsync_pin_i;
   logic       vsync_pin_i;
   logic       hblank_pin_i;
   logic       fmt_480i_pin_i;
   logic       reg_wr_i;
   logic       reg_rd_i;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic [7:0] reg_rdata_o;
   logic [7:0] red_i;
   logic [7:0] green_i;
   logic [7:0] blue_i;
   logic [7:0] red_o;
   logic [7:0] green_o;
   logic [7:0] blue_o;
   logic       ref_pulse_o;
   logic       vblank_o;
   logic [7:0] red_q;
   logic [7:0] green_q;
   logic [7:0] blue_q;
   int         n_fail;
   int         total_checks;
   int         cyc;
   int         st;

   ////////////////////////////////////////////////////////////////////////////
   // design and sync source
   rbt_timing rbt_timing_inst (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsync_pin_i(hsync_pin_i),
      .vsync_pin_i(vsync_pin_i), .hblank_pin_i(hblank_pin_i), .fmt_480i_pin_i(fmt_480i_pin_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .red_i(red_i), .green_i(green_i),
      .blue_i(blue_i), .red_o(red_o), .green_o(green_o), .blue_o(blue_o),
      .ref_pulse_o(ref_pulse_o), .vblank_o(vblank_o));

   rbt_sync_src rbt_sync_src_inst (.sys_clk_i(sys_clk_i), .hsync_o(hsync_pin_i), .vsync_o(vsync_pin_i));

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang limit
   initial sys_clk_i = 1'h0;
   always #2.5 sys_clk_i = ~sys_clk_i;

   // moving video codes; the _q copies hold what the design sampled last edge
   always @(posedge sys_clk_i) begin
      red_q   <= red_i;
      green_q <= green_i;
      blue_q  <= blue_i;
      if (!resetn_i) begin
         red_i   <= 8'h5A;
         green_i <= 8'hA5;
         blue_i  <= 8'h3C;
      end else begin
         red_i   <= red_i + 8'h03;
         green_i <= green_i - 8'h05;
         blue_i  <= blue_i + 8'h07;
      end
   end

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      total_checks++;
      if (got !== ex) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask

   task automatic chk3(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
      chk("red_o", r, red_o);
      chk("green_o", g, green_o);
      chk("blue_o", b, blue_o);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'h1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ex);
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'h1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'h0;
      @(posedge sys_clk_i);
      #1;
      chk("reg_rdata_o", ex, reg_rdata_o);
   endtask

   task automatic pause();
      repeat (4) @(posedge sys_clk_i);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      n_fail = 0; total_checks = 0; cyc = 0;
      resetn_i = 1'h0; hblank_pin_i = 1'h0; fmt_480i_pin_i = 1'h1;
      reg_wr_i = 1'h0; reg_rd_i = 1'h0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
      repeat (2) @(posedge sys_clk_i);
      resetn_i <= 1'h1;
      repeat (3) @(posedge sys_clk_i);
      // reset values, unmapped and unimplemented bits
      rd(RBT_ADDR_VIDEO_EN, 8'h70);
      rd(RBT_ADDR_AGING, 8'h00);
      rd(RBT_ADDR_CUTOFF, 8'h00);
      rd(RBT_ADDR_VBLANK, 8'h00);
      rd(RBT_ADDR_VSELECT, 8'h01);
      rd(8'h03, 8'h00);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(20);
      chk3(8'h00, 8'h00, 8'h00);
      $display("test reset done");
      // reference pulse at code 0 and code 1F
      wr(RBT_ADDR_VIDEO_EN, 8'hF0);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(5);
      chk3(8'h00, 8'h00, 8'h00);
      rbt_sync_src_inst.line_step(5);
      chk("ref_pulse_o", 8'h01, {7'h00, ref_pulse_o});
      chk("blue_o", RBT_LVL_REF, blue_o);
      rbt_sync_src_inst.line_step(1);
      chk3(red_q, green_q, blue_q);
      wr(RBT_ADDR_CUTOFF, 8'hFC);
      rd(RBT_ADDR_CUTOFF, 8'hF8);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(40);
      chk("ref_pulse_o", 8'h00, {7'h00, ref_pulse_o});
      rbt_sync_src_inst.line_step(1);
      chk("ref_pulse_o", 8'h01, {7'h00, ref_pulse_o});
      rbt_sync_src_inst.line_step(1);
      chk3(red_q, green_q, blue_q);
      wr(RBT_ADDR_CUTOFF, 8'h00);
      $display("test reference line done");
      // top blanking in both formats, then select off
      wr(RBT_ADDR_VBLANK, 8'h30);
      for (int f = 0; f < 2; f++) begin
         fmt_480i_pin_i <= (f == 0);
         st = (f == 0) ? 1 : 2;
         rbt_sync_src_inst.field_start();
         rbt_sync_src_inst.line_step(10 + 3 * st);
         chk3(8'h00, 8'h00, 8'h00);
         chk("vblank_o", 8'h01, {7'h00, vblank_o});
         rbt_sync_src_inst.line_step(1);
         chk3(red_q, green_q, blue_q);
         chk("vblank_o", 8'h00, {7'h00, vblank_o});
      end
      fmt_480i_pin_i <= 1'h1;
      wr(RBT_ADDR_VSELECT, 8'h00);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(11);
      chk3(red_q, green_q, blue_q);
      wr(RBT_ADDR_VSELECT, 8'h01);
      wr(RBT_ADDR_VBLANK, 8'h00);
      $display("test top blanking done");
      // channel enables and master off on the pulse line
      wr(RBT_ADDR_VIDEO_EN, 8'hE0);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(10);
      chk("blue_o", RBT_LVL_REF, blue_o);
      wr(RBT_ADDR_VIDEO_EN, 8'h70);
      pause();
      chk("ref_pulse_o", 8'h00, {7'h00, ref_pulse_o});
      chk("blue_o", 8'h00, blue_o);
      rbt_sync_src_inst.line_step(1);
      wr(RBT_ADDR_VIDEO_EN, 8'hE0);
      pause();
      chk3(red_q, green_q, 8'h00);
      wr(RBT_ADDR_VIDEO_EN, 8'hB0);
      pause();
      chk3(8'h00, green_q, blue_q);
      wr(RBT_ADDR_VIDEO_EN, 8'hF0);
      $display("test enables done");
      // manual cut-off and blanking switch
      wr(RBT_ADDR_CUTOFF, 8'h01);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(10);
      chk("ref_pulse_o", 8'h00, {7'h00, ref_pulse_o});
      chk3(8'h00, 8'h00, 8'h00);
      wr(RBT_ADDR_CUTOFF, 8'h03);
      pause();
      chk3(RBT_LVL_BLANK_OFF, RBT_LVL_BLANK_OFF, RBT_LVL_BLANK_OFF);
      rbt_sync_src_inst.line_step(1);
      hblank_pin_i <= 1'h1;
      repeat (6) @(posedge sys_clk_i);
      #1;
      chk3(RBT_LVL_BLANK_OFF, RBT_LVL_BLANK_OFF, RBT_LVL_BLANK_OFF);
      wr(RBT_ADDR_CUTOFF, 8'h01);
      pause();
      chk3(8'h00, 8'h00, 8'h00);
      hblank_pin_i <= 1'h0;
      wr(RBT_ADDR_CUTOFF, 8'h00);
      $display("test manual cut-off done");
      // aging modes over live video
      wr(RBT_ADDR_AGING, 8'h02);
      pause();
      chk3(RBT_LVL_WHITE, RBT_LVL_WHITE, RBT_LVL_WHITE);
      wr(RBT_ADDR_AGING, 8'h01);
      pause();
      chk3(8'h00, 8'h00, 8'h00);
      wr(RBT_ADDR_AGING, 8'h03);
      pause();
      chk3(8'h00, 8'h00, 8'h00);
      wr(RBT_ADDR_AGING, 8'h00);
      pause();
      chk3(red_q, green_q, blue_q);
      $display("test aging done");
      // bottom blanking from the previous field length
      wr(RBT_ADDR_VBLANK, 8'h02);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(40);
      rbt_sync_src_inst.field_start();
      rbt_sync_src_inst.line_step(37);
      chk3(red_q, green_q, blue_q);
      chk("vblank_o", 8'h00, {7'h00, vblank_o});
      rbt_sync_src_inst.line_step(2);
      chk3(8'h00, 8'h00, 8'h00);
      chk("vblank_o", 8'h01, {7'h00, vblank_o});
      $display("test bottom blanking done");
      print_verdict();
   end

endmodule
